/* File: core/sdc_clk_div.sv */
// Converter clock divider producing a one-cycle enable pulse.
// Assumes the divide value is at least one.
`timescale 1ns/100ps
`default_nettype none
module sdc_clk_div
(
    input  wire logic     clk_i,
    input  wire logic     nrst_i,
    sdc_conv_if.gen       cif
);
    import sdc_pkg::*;
    logic [6:0] cnt_q;
    logic       tick_q;
    assign cif.tick = tick_q;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (!cif.run)
        begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b0;
        end
        else if (cnt_q + 7'h01 >= cif.div)
        begin
            cnt_q  <= 7'h00;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end
endmodule // sdc_clk_div
`default_nettype wire

/* File: core/sdc_conv_if.sv */
// Interface joining the control logic and the converter clock divider.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface sdc_conv_if;
    logic       run;
    logic [6:0] div;
    logic       tick;
    modport ctrl (output run, output div, input tick);
    modport gen  (input run, input div, output tick);
endinterface
`default_nettype wire

/* File: core/sdc_core.sv */
// Control and result formatting for a 10-bit successive-approximation converter.
// Assumes an analog front end that answers a compare request each converter tick.
`timescale 1ns/100ps
`default_nettype none
module sdc_core
#(
    parameter int RES_BITS = 10
)
(
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic [2:0]           addr_i,
    input  wire logic [7:0]           wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [7:0]           rdata_o,
    input  wire logic [2:0]           timer_ovf_i,
    input  wire logic                 cmp_i,
    output logic                      sample_o,
    output logic      [2:0]           chan_o,
    output logic                      diff_o,
    output logic                      connect_o,
    output logic                      int_ref_o,
    output logic                      power_o,
    output logic                      dac_mode_o,
    output logic      [9:0]           trial_o,
    output logic                      done_irq_o
);
    import sdc_pkg::*;

    if (RES_BITS != RES_W)
    begin : g_res_check
        $error("sdc_core supports only a 10-bit engine");
    end

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    logic [7:0]  ctrl_q;
    logic [7:0]  input_q;
    logic [9:0]  result_q;
    logic [9:0]  dac_data_q;
    logic [9:0]  dac_buf_q;
    logic [9:0]  sar_q;
    logic [9:0]  bit_q;
    logic [3:0]  tick_cnt_q;
    logic        done_q;
    logic        busy_q;
    sdc_state_t  state_q;

    sdc_conv_if cif();

    sdc_clk_div u_div
    (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .cif    (cif)
    );

    logic        is_dac;
    logic        left;
    logic [15:0] aligned;
    logic        trig;
    logic        sw_start;
    logic        tick;
    logic        last_tick;
    logic [3:0]  conv_len;
    logic        power_now;

    assign is_dac   = ctrl_q[CTRL_DAC_BIT];
    assign left     = ctrl_q[CTRL_LEFT_BIT];
    assign tick     = cif.tick;
    assign cif.run  = busy_q;
    // Converter clock is the base divide times a power of two cut to 7 bits; field 7 wraps the divide to 0,
    // a tick every clock, above its limit. An ADC conversion lasts 13 ticks, a DAC one 11.
    assign cif.div  = DIV_BASE << ctrl_q[CTRL_DIV_LSB +: CTRL_DIV_W];
    assign conv_len = is_dac ? 4'(DAC_CYCLES) : 4'(ADC_CYCLES);
    assign last_tick = tick && (tick_cnt_q == conv_len);
    assign power_now = (wr_i && addr_i == ADDR_CTRL) ? wdata_i[CTRL_POWER_BIT]
                                                     : ctrl_q[CTRL_POWER_BIT];

    // Trigger code zero is software only; codes 1 to 3 pick a timer.
    always_comb
    begin
        unique case (input_q[IN_TRG_LSB +: IN_TRG_W])
            2'b00: trig = 1'b0;
            2'b01: trig = timer_ovf_i[0];
            2'b10: trig = timer_ovf_i[1];
            2'b11: trig = timer_ovf_i[2];
        endcase
    end

    assign sw_start = wr_i && (addr_i == ADDR_CTRL) && wdata_i[CTRL_START_BIT];

    // Result alignment.
    always_comb
    begin
        if (left)
        begin
            aligned = {result_q, 6'h00};
        end
        else
        begin
            aligned = {{6{result_q[9]}}, result_q};
        end
    end

    // -------------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_q  <= CTRL_RESET;
            input_q <= INPUT_RESET;
        end
        else
        begin
            if (wr_i && addr_i == ADDR_CTRL)
            begin
                ctrl_q <= wdata_i & ~(8'h01 << CTRL_START_BIT);
            end
            if (wr_i && addr_i == ADDR_INPUT && !busy_q)
            begin
                input_q <= wdata_i;
            end
        end
    end

    // DAC data is writable only in DAC mode.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dac_data_q <= 10'h000;
        end
        else if (wr_i && is_dac)
        begin
            if (addr_i == ADDR_HIGH)
            begin
                dac_data_q[9:2] <= left ? wdata_i : {wdata_i[1:0], dac_data_q[7:2]};
            end
            else if (addr_i == ADDR_LOW)
            begin
                dac_data_q[1:0] <= left ? wdata_i[7:6] : wdata_i[1:0];
                if (!left)
                begin
                    dac_data_q[9:2] <= {dac_data_q[9:8], wdata_i[7:2]};
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Conversion sequencer
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_q    <= SDC_IDLE;
            busy_q     <= 1'b0;
            tick_cnt_q <= 4'h0;
            sar_q      <= 10'h000;
            bit_q      <= 10'h000;
            dac_buf_q  <= 10'h000;
            result_q   <= 10'h000;
            sample_o   <= 1'b0;
        end
        else
        begin
            sample_o <= 1'b0;
            unique case (state_q)
                SDC_IDLE:
                begin
                    if (power_now && (sw_start || trig))
                    begin
                        busy_q     <= 1'b1;
                        state_q    <= SDC_RUN;
                        tick_cnt_q <= 4'h1;
                        dac_buf_q  <= dac_data_q;
                        sar_q      <= 10'h000;
                        bit_q      <= 10'h200;
                    end
                end
                SDC_RUN:
                begin
                    if (tick)
                    begin
                        tick_cnt_q <= tick_cnt_q + 4'h1;
                        if (!is_dac && tick_cnt_q == 4'(SAMPLE_CYCLE))
                        begin
                            sample_o <= 1'b1;
                        end
                        // Bit trials follow the sample in ADC mode and start at
                        // once in DAC mode.
                        if (bit_q != 10'h000 &&
                            (is_dac ? tick_cnt_q >= 4'h1 : tick_cnt_q > 4'(SAMPLE_CYCLE)))
                        begin
                            if (!is_dac && cmp_i)
                            begin
                                sar_q <= sar_q | bit_q;
                            end
                            else if (is_dac)
                            begin
                                sar_q <= dac_buf_q & (sar_q | bit_q | (bit_q - 10'h001));
                            end
                            bit_q <= bit_q >> 1;
                        end
                        if (last_tick)
                        begin
                            state_q <= SDC_FINISH;
                        end
                    end
                end
                SDC_FINISH:
                begin
                    if (!is_dac)
                    begin
                        // Sign bit is the top trial bit inverted, giving two's complement.
                        result_q <= {~sar_q[9], sar_q[8:0]};
                    end
                    busy_q  <= 1'b0;
                    state_q <= SDC_IDLE;
                end
                default:
                begin
                    state_q <= SDC_IDLE;
                end
            endcase
        end
    end

    // Done flag: set wins over a software clear in the same cycle.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            done_q <= 1'b0;
        end
        else if (state_q == SDC_FINISH)
        begin
            done_q <= 1'b1;
        end
        else if (wr_i && addr_i == ADDR_STATUS && wdata_i[STAT_DONE_BIT])
        begin
            done_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (rd_i)
        begin
            unique case (addr_i)
                ADDR_CTRL:   rdata_o <= ctrl_q | ({7'h00, busy_q} << CTRL_START_BIT);
                ADDR_INPUT:  rdata_o <= input_q;
                ADDR_HIGH:   rdata_o <= is_dac ? 8'h00 : aligned[15:8];
                ADDR_LOW:    rdata_o <= is_dac ? 8'h00 : aligned[7:0];
                ADDR_STATUS: rdata_o <= {6'h00, busy_q, done_q};
                default:     rdata_o <= 8'h00;
            endcase
        end
        else
        begin
            rdata_o <= 8'h00;
        end
    end

    // -------------------------------------------------------------------------
    // Analog front-end controls
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            chan_o     <= 3'h0;
            diff_o     <= 1'b0;
            connect_o  <= 1'b0;
            int_ref_o  <= 1'b0;
            power_o    <= 1'b0;
            dac_mode_o <= 1'b0;
            trial_o    <= 10'h000;
            done_irq_o <= 1'b0;
        end
        else
        begin
            diff_o <= input_q[IN_DIFF_BIT];
            // Out-of-range channel codes clamp to the last legal one.
            if (input_q[IN_DIFF_BIT])
            begin
                chan_o <= (input_q[2:0] > MAX_DIFF_PAIR) ? MAX_DIFF_PAIR : input_q[2:0];
            end
            else
            begin
                chan_o <= (input_q[2:0] > MAX_SINGLE_CHAN) ? MAX_SINGLE_CHAN : input_q[2:0];
            end
            connect_o  <= input_q[IN_CONNECT_BIT];
            int_ref_o  <= ctrl_q[CTRL_IREF_BIT];
            power_o    <= ctrl_q[CTRL_POWER_BIT];
            dac_mode_o <= is_dac;
            trial_o    <= sar_q | bit_q;
            done_irq_o <= done_q;
        end
    end
endmodule // sdc_core
`default_nettype wire

/* File: core/sdc_pkg.sv */
// Package of constants for the data converter control block.
// Assumes an 8-bit register port and a 25 MHz system clock.
package sdc_pkg;
    // -------------------------------------------------------------------------
    // Register offsets
    // -------------------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_INPUT  = 3'h1;
    localparam logic [2:0] ADDR_HIGH   = 3'h2;
    localparam logic [2:0] ADDR_LOW    = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    // -------------------------------------------------------------------------
    // Control register fields
    // -------------------------------------------------------------------------
    localparam int CTRL_POWER_BIT = 7;
    localparam int CTRL_START_BIT = 6;
    localparam int CTRL_LEFT_BIT  = 5;
    localparam int CTRL_DAC_BIT   = 4;
    localparam int CTRL_IREF_BIT  = 3;
    localparam int CTRL_DIV_LSB   = 0;
    localparam int CTRL_DIV_W     = 3;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    // -------------------------------------------------------------------------
    // Input register fields
    // -------------------------------------------------------------------------
    localparam int IN_CONNECT_BIT = 7;
    localparam int IN_TRG_LSB     = 4;
    localparam int IN_TRG_W       = 2;
    localparam int IN_DIFF_BIT    = 3;
    localparam int IN_CHAN_LSB    = 0;
    localparam int IN_CHAN_W      = 3;
    localparam logic [7:0] INPUT_RESET = 8'h00;
    localparam logic [2:0] MAX_SINGLE_CHAN = 3'h6;
    localparam logic [2:0] MAX_DIFF_PAIR   = 3'h2;
    // -------------------------------------------------------------------------
    // Status register fields
    // -------------------------------------------------------------------------
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    // -------------------------------------------------------------------------
    // Conversion timing
    // -------------------------------------------------------------------------
    localparam int RES_W         = 10;
    localparam int ADC_CYCLES    = 13;
    localparam int DAC_CYCLES    = 11;
    localparam int SAMPLE_CYCLE  = 3;
    localparam int SYS_CLK_HZ    = 25_000_000;
    localparam int CONV_CLK_MAX_HZ = 2_000_000;
    // Least system-clock divide that keeps the converter clock at or below its limit.
    localparam int MIN_DIV = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
    localparam logic [6:0] DIV_BASE = 7'(MIN_DIV);
    typedef enum logic [1:0] {
        SDC_IDLE   = 2'b00,
        SDC_RUN    = 2'b01,
        SDC_FINISH = 2'b10
    } sdc_state_t;
endpackage

/* File: verif/sdc_afe_model.sv */
// Behavioural analog front end: sample-and-hold plus comparator.
// Assumes the block under test drives an offset-binary trial word.
`timescale 1ns/100ps
`default_nettype none
module sdc_afe_model
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       sample_i,
    input  wire logic [9:0] trial_i,
    input  wire logic [9:0] level_i,
    output logic            cmp_o
);
    logic [9:0] held_q;

    // The level is a signed code; flipping its sign bit gives the offset form.
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            held_q <= 10'h000;
        else if (sample_i)
            held_q <= level_i ^ 10'h200;

    assign cmp_o = (trial_i <= held_q);
endmodule // sdc_afe_model
`default_nettype wire

/* File: verif/sdc_core_chk.sv */
// Port checker for the converter control block.
// Assumes conversions are started with a divider field of zero.
`timescale 1ns/100ps
`default_nettype none
module sdc_core_chk
    import sdc_pkg::*;
#(
    parameter int RES_BITS = 10
)
(
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [2:0] timer_ovf_i,
    input wire logic       cmp_i,
    input wire logic       sample_o,
    input wire logic [2:0] chan_o,
    input wire logic       diff_o,
    input wire logic       connect_o,
    input wire logic       int_ref_o,
    input wire logic       power_o,
    input wire logic       dac_mode_o,
    input wire logic [9:0] trial_o,
    input wire logic       done_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    logic clr_w;
    assign clr_w = wr_i && addr_i == ADDR_STATUS && wdata_i[STAT_DONE_BIT];

    rd_idle_zero_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero without a read");
    dac_read_zero_a: assert property (
        rd_i && dac_mode_o && (addr_i == ADDR_HIGH || addr_i == ADDR_LOW) |=> rdata_o == 8'h00)
        else $error("data register readable in output mode");
    sample_power_a: assert property (sample_o |-> power_o && !dac_mode_o)
        else $error("sample pulse outside powered input mode");
    sample_pulse_a: assert property (sample_o |=> !sample_o)
        else $error("sample pulse longer than one cycle");
    start_sample_a: assert property (
        wr_i && addr_i == ADDR_CTRL && (wdata_i == 8'hC0 || wdata_i == 8'hE0)
        |-> ##[14:60] sample_o)
        else $error("no sample on the third converter tick");
    sample_done_a: assert property (sample_o |-> ##[110:160] done_irq_o)
        else $error("done flag missing after thirteen ticks");
    done_hold_a: assert property ($fell(done_irq_o) |-> $past(clr_w) || $past(clr_w, 2))
        else $error("done flag dropped without a clear");
    cfg_stable_a: assert property (!wr_i [*2] |=> $stable({chan_o, diff_o, connect_o}))
        else $error("input selection changed without a write");
    mode_stable_a: assert property (
        !wr_i [*2] |=> $stable({power_o, int_ref_o, dac_mode_o}))
        else $error("mode outputs changed without a write");
endmodule // sdc_core_chk

bind sdc_core sdc_core_chk #(.RES_BITS(RES_BITS)) sdc_core_chk_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .timer_ovf_i(timer_ovf_i), .cmp_i(cmp_i), .sample_o(sample_o),
    .chan_o(chan_o), .diff_o(diff_o), .connect_o(connect_o), .int_ref_o(int_ref_o),
    .power_o(power_o), .dac_mode_o(dac_mode_o), .trial_o(trial_o), .done_irq_o(done_irq_o));
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the analog front end model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sdc_pkg::*;
    logic       clk_i = 1'b0;
    logic       nrst_i, wr_i, rd_i, sample_o, diff_o, connect_o, int_ref_o;
    logic       power_o, dac_mode_o, done_irq_o;
    logic [2:0] addr_i, timer_ovf_i, chan_o;
    logic [7:0] wdata_i, rdata_o;
    logic [9:0] trial_o, level;
    wire        cmp_i;
    int         error_cnt = 0;
    int         tests_run = 0;
    logic [9:0]  codes [5] = '{10'h000, 10'h100, 10'h1FF, 10'h300, 10'h201};
    logic [15:0] rgt [5] = '{16'h0000, 16'h0100, 16'h01FF, 16'hFF00, 16'hFE01};
    logic [15:0] lft [5] = '{16'h0000, 16'h4000, 16'h7FC0, 16'hC000, 16'h8040};

    always #20 clk_i = ~clk_i;

    sdc_core #(.RES_BITS(10)) sdc_core_i (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_ovf_i(timer_ovf_i), .cmp_i(cmp_i), .sample_o(sample_o), .chan_o(chan_o),
        .diff_o(diff_o), .connect_o(connect_o), .int_ref_o(int_ref_o), .power_o(power_o),
        .dac_mode_o(dac_mode_o), .trial_o(trial_o), .done_irq_o(done_irq_o));
    sdc_afe_model sdc_afe_model_i (.clk_i(clk_i), .nrst_i(nrst_i), .sample_i(sample_o),
        .trial_i(trial_o), .level_i(level), .cmp_o(cmp_i));

    task automatic close_out();
        $display("mismatches %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done_irq_o !== 1'b1 && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n == 2000)
        begin
            chk("done wait", 16'h0001, 16'h0000);
            close_out();
        end
    endtask

    // Clears the done flag, starts one conversion and reads both data bytes.
    task automatic conv(input logic [7:0] ctrl, output logic [15:0] res);
        logic [7:0] d;
        wr(ADDR_STATUS, 8'h01);
        wr(ADDR_CTRL, ctrl);
        rd(ADDR_CTRL, d);
        chk("busy while running", 16'h0001, 16'(d[CTRL_START_BIT]));
        wait_done();
        rd(ADDR_CTRL, d);
        chk("busy after finish", 16'h0000, 16'(d[CTRL_START_BIT]));
        rd(ADDR_HIGH, res[15:8]);
        rd(ADDR_LOW, res[7:0]);
    endtask

    initial
    begin
        logic [15:0] r;
        logic [7:0]  d;
        logic [7:0]  b;
        logic [9:0]  u;
        nrst_i      = 1'b0;
        addr_i      = 3'h0;
        wdata_i     = 8'h00;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        timer_ovf_i = 3'h0;
        level       = 10'h000;
        repeat (6) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(ADDR_CTRL, d);
        chk("control reset", 16'(CTRL_RESET), 16'(d));
        rd(ADDR_INPUT, d);
        chk("input reset", 16'(INPUT_RESET), 16'(d));
        rd(3'h5, d);
        chk("unmapped read", 16'h0000, 16'(d));
        for (int i = 0; i < 10; i++)
        begin
            b = (i < 7) ? 8'h80 + 8'(i) : 8'h81 + 8'(i);
            wr(ADDR_INPUT, b);
            repeat (3) @(posedge clk_i);
            chk("input fields", 16'({b[7], b[3], b[2:0]}), 16'({connect_o, diff_o, chan_o}));
        end
        wr(ADDR_INPUT, 8'h87);
        repeat (3) @(posedge clk_i);
        chk("single channel clamp", 16'(MAX_SINGLE_CHAN), 16'(chan_o));
        wr(ADDR_INPUT, 8'h8F);
        repeat (3) @(posedge clk_i);
        chk("pair clamp", 16'(MAX_DIFF_PAIR), 16'(chan_o));
        wr(ADDR_INPUT, 8'h80);
        for (int i = 0; i < 10; i++)
        begin
            level = codes[i % 5];
            conv((i < 5) ? 8'hC0 : 8'hE0, r);
            chk("result pair", (i < 5) ? rgt[i] : lft[i - 5], r);
            u = codes[i % 5] ^ 10'h200;
            b = r[15:8] + ((i < 5) ? 8'h02 : 8'h80);
            chk("unsigned high", (i < 5) ? 16'(u[9:8]) : 16'(u[9:2]), 16'(b));
        end
        wr(ADDR_HIGH, 8'h55);
        rd(ADDR_HIGH, d);
        chk("high after write", 16'h0080, 16'(d));
        level = 10'h100;
        wr(ADDR_STATUS, 8'h01);
        wr(ADDR_CTRL, 8'h88);
        wr(ADDR_INPUT, 8'hA0);
        chk("reference and power", 16'h0003, 16'({int_ref_o, power_o}));
        @(posedge clk_i);
        timer_ovf_i <= 3'b001;
        @(posedge clk_i);
        timer_ovf_i <= 3'b000;
        repeat (60) @(posedge clk_i);
        rd(ADDR_STATUS, d);
        chk("other timer ignored", 16'h0000, 16'(d));
        @(posedge clk_i);
        timer_ovf_i <= 3'b010;
        @(posedge clk_i);
        timer_ovf_i <= 3'b000;
        wait_done();
        rd(ADDR_HIGH, r[15:8]);
        rd(ADDR_LOW, r[7:0]);
        chk("timer result", 16'h0100, r);
        wr(ADDR_CTRL, 8'h90);
        wr(ADDR_HIGH, 8'h01);
        wr(ADDR_LOW, 8'h23);
        chk("output mode", 16'h0001, 16'(dac_mode_o));
        conv(8'hD0, r);
        chk("output mode readback", 16'h0000, r);
        chk("output value", 16'h0123, 16'(trial_o));
        wr(ADDR_STATUS, 8'h01);
        repeat (3) @(posedge clk_i);
        rd(ADDR_STATUS, d);
        chk("done cleared", 16'h0000, 16'({d[STAT_DONE_BIT], done_irq_o}));
        close_out();
    end
endmodule // tb_top
`default_nettype wire
